// ---- rtl/iord_pkg.sv ----
package iord_pkg;
   localparam int IORD_NREG = 64;
   localparam logic [7:0] IORD_DATA_OFS = 8'h20;
   localparam logic [7:0] IORD_EXT_LO = 8'h60;
   localparam logic [5:0] IORD_BIT_LIMIT = 6'h1f;
   localparam logic [7:0] IORD_RESET_VAL = 8'h00;
   localparam logic [5:0] IORD_A_PIN_A = 6'h00;
   localparam logic [5:0] IORD_A_PIN_B = 6'h03;
   localparam logic [5:0] IORD_A_PIN_C = 6'h06;
   localparam logic [5:0] IORD_A_PIN_D = 6'h09;
   localparam logic [5:0] IORD_A_TMR0_FLG = 6'h15;
   localparam logic [5:0] IORD_A_TMR1_FLG = 6'h16;
   localparam logic [5:0] IORD_A_TMR2_FLG = 6'h17;
   localparam logic [5:0] IORD_A_TMR3_FLG = 6'h18;
   localparam logic [5:0] IORD_A_PCH_FLG = 6'h1b;
   localparam logic [5:0] IORD_A_EXT_FLG = 6'h1c;
   // implemented-bit mask per location; zero marks reserved
   localparam logic [63:0][7:0] IORD_IMPL = '{
      6'h00: 8'hff, 6'h01: 8'hff, 6'h02: 8'hff, 6'h03: 8'hff, 6'h04: 8'hff,
      6'h05: 8'hff, 6'h06: 8'hff, 6'h07: 8'hff, 6'h08: 8'hff, 6'h09: 8'hff,
      6'h0a: 8'hff, 6'h0b: 8'hff, 6'h15: 8'h07, 6'h16: 8'h27, 6'h17: 8'h07,
      6'h18: 8'h27, 6'h1b: 8'h0f, 6'h1c: 8'h07, 6'h1d: 8'h07, 6'h1e: 8'hff,
      6'h1f: 8'h3f, 6'h20: 8'hff, 6'h21: 8'hff, 6'h22: 8'hff, 6'h23: 8'h83,
      6'h24: 8'hf3, 6'h25: 8'hcf, 6'h26: 8'hff, 6'h27: 8'hff, 6'h28: 8'hff,
      6'h2a: 8'hff, 6'h2b: 8'hff, 6'h2c: 8'hff, 6'h2d: 8'hc1, 6'h2e: 8'hff,
      6'h30: 8'hff, 6'h31: 8'hff, 6'h33: 8'h0f, 6'h34: 8'h1f,
      default: 8'h00};
   typedef enum logic [2:0] {
      IORD_OP_NONE, IORD_OP_IO_RD, IORD_OP_IO_WR, IORD_OP_SET_BIT,
      IORD_OP_CLR_BIT, IORD_OP_TEST_BIT, IORD_OP_DATA_LD, IORD_OP_DATA_ST
   } iord_op_e;
   typedef struct packed {
      iord_op_e op;
      logic [7:0] addr;
      logic [2:0] bit_sel;
      logic [7:0] wdata;
   } iord_req_s;
   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
      logic bit_val;
      logic reject;
      logic ext_sel;
   } iord_rsp_s;
endpackage

// ---- rtl/iord_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module iord_decoder
   import iord_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire iord_req_s req,
   output iord_rsp_s rsp,
   output logic [7:0] ext_addr,
   output logic ext_wr,
   output logic [7:0] ext_wdata,
   input wire logic [7:0] ext_rdata,
   input wire logic [31:0] pin_levels,
   input wire logic [511:0] flag_set,
   output logic [63:0][7:0] reg_out
);
   logic rst_m_q, rst_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_m_q <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_q <= rst_m_q;
      end
   end

   // pin sampling, three stages, change taken when stages two and three agree
   logic [31:0] pin1_q, pin2_q, pin3_q, pin_st_q, pin_st_d;
   always_comb begin
      pin_st_d = pin_st_q;
      for (int i = 0; i < 32; i++) begin
         if (pin2_q[i] == pin3_q[i]) begin
            pin_st_d[i] = pin3_q[i];
         end
      end
   end
   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         pin1_q <= '0;
         pin2_q <= '0;
         pin3_q <= '0;
         pin_st_q <= '0;
      end else begin
         pin1_q <= pin_levels;
         pin2_q <= pin1_q;
         pin3_q <= pin2_q;
         pin_st_q <= pin_st_d;
      end
   end

   function automatic logic is_flag_reg(input logic [5:0] a);
      return a == IORD_A_TMR0_FLG || a == IORD_A_TMR1_FLG || a == IORD_A_TMR2_FLG ||
             a == IORD_A_TMR3_FLG || a == IORD_A_PCH_FLG || a == IORD_A_EXT_FLG;
   endfunction
   function automatic logic is_pin_reg(input logic [5:0] a);
      return a == IORD_A_PIN_A || a == IORD_A_PIN_B || a == IORD_A_PIN_C ||
             a == IORD_A_PIN_D;
   endfunction

   // address decode
   logic sel_io, sel_wr, sel_bit, sel_rd, sel_ext, rej;
   logic [5:0] idx;
   logic [7:0] cur, wval;
   always_comb begin
      sel_io = 1'b0;
      sel_wr = 1'b0;
      sel_bit = 1'b0;
      sel_rd = 1'b0;
      sel_ext = 1'b0;
      rej = 1'b0;
      idx = req.addr[5:0];
      unique case (req.op)
         IORD_OP_NONE: ;
         IORD_OP_IO_RD, IORD_OP_IO_WR: begin
            rej = req.addr[7:6] != 2'b00;
            sel_io = !rej;
            sel_wr = !rej && req.op == IORD_OP_IO_WR;
            sel_rd = !rej && req.op == IORD_OP_IO_RD;
         end
         IORD_OP_SET_BIT, IORD_OP_CLR_BIT, IORD_OP_TEST_BIT: begin
            rej = req.addr > {2'b00, IORD_BIT_LIMIT};
            sel_io = !rej;
            sel_bit = !rej;
            sel_wr = !rej && req.op != IORD_OP_TEST_BIT;
         end
         IORD_OP_DATA_LD, IORD_OP_DATA_ST: begin
            if (req.addr >= IORD_EXT_LO) begin
               sel_ext = 1'b1;
            end else if (req.addr >= IORD_DATA_OFS) begin
               idx = 6'(req.addr - IORD_DATA_OFS);
               sel_io = 1'b1;
               sel_wr = req.op == IORD_OP_DATA_ST;
               sel_rd = req.op == IORD_OP_DATA_LD;
            end else begin
               rej = 1'b1;
            end
         end
         default: rej = 1'b1;
      endcase
   end

   logic [63:0][7:0] regs_q, regs_d;
   always_comb begin
      cur = regs_q[idx];
      wval = req.wdata;
      if (sel_bit) begin
         wval = cur;
         wval[req.bit_sel] = req.op == IORD_OP_SET_BIT;
      end
   end

   genvar g;
   generate
      for (g = 0; g < IORD_NREG; g++) begin : g_reg
         localparam logic [5:0] A = 6'(g);
         always_comb begin
            regs_d[g] = regs_q[g];
            if (is_pin_reg(A)) begin
               // index folded into range; only pin locations reach this branch
               regs_d[g] = pin_st_q[8*((g/3)%4) +: 8];
            end else if (is_flag_reg(A)) begin
               // set beats clear in the same cycle
               if (sel_wr && idx == A) begin
                  regs_d[g] = regs_q[g] & ~wval;
               end
               regs_d[g] = (regs_d[g] | flag_set[g*8 +: 8]) & IORD_IMPL[g];
            end else if (sel_wr && idx == A) begin
               regs_d[g] = wval & IORD_IMPL[g];
            end
         end
      end
   endgenerate

   iord_rsp_s rsp_d;
   always_comb begin
      rsp_d = '0;
      rsp_d.valid = req.op != IORD_OP_NONE;
      rsp_d.reject = rej;
      rsp_d.ext_sel = sel_ext;
      if (sel_ext) begin
         rsp_d.rdata = ext_rdata;
      end else if (sel_rd) begin
         rsp_d.rdata = cur & IORD_IMPL[idx];
      end
      if (sel_bit) begin
         rsp_d.bit_val = cur[req.bit_sel];
      end
   end

   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         regs_q <= '{default: IORD_RESET_VAL};
         rsp <= '0;
      end else begin
         regs_q <= regs_d;
         rsp <= rsp_d;
      end
   end

   assign ext_addr = req.addr;
   assign ext_wr = sel_ext && req.op == IORD_OP_DATA_ST;
   assign ext_wdata = req.wdata;
   assign reg_out = regs_q;

   a_bit_range: assert property (@(posedge clk) disable iff (!rst_q)
      (req.op inside {IORD_OP_SET_BIT, IORD_OP_CLR_BIT} && req.addr > 8'h1f)
      |=> rsp.reject && $stable(regs_q))
      else $error("bit op outside low range accepted");
   a_w1c_clear: assert property (@(posedge clk) disable iff (!rst_q)
      (req.op == IORD_OP_IO_WR && req.addr == 8'h15 && flag_set[8'h15*8 +: 8] == 8'h00)
      |=> regs_q[6'h15] == ($past(regs_q[6'h15]) & ~$past(req.wdata)))
      else $error("flag clear wrong");
   a_set_wins: assert property (@(posedge clk) disable iff (!rst_q)
      flag_set[8'h1c*8] |=> regs_q[6'h1c][0])
      else $error("flag set lost");
   a_bitop_flags: assert property (@(posedge clk) disable iff (!rst_q)
      (req.op == IORD_OP_SET_BIT && req.addr == 8'h16 && flag_set[8'h16*8 +: 8] == 8'h00)
      |=> regs_q[6'h16] == 8'h00)
      else $error("bit op did not clear flags");
   a_bit_test: assert property (@(posedge clk) disable iff (!rst_q)
      (req.op == IORD_OP_TEST_BIT && req.addr <= 8'h1f)
      |=> rsp.bit_val == $past(regs_q[req.addr[5:0]][req.bit_sel]))
      else $error("bit test value wrong");
   a_resv_stay: assert property (@(posedge clk) disable iff (!rst_q)
      regs_q[6'h0c] == 8'h00)
      else $error("reserved location holds data");
   a_short_noext: assert property (@(posedge clk) disable iff (!rst_q)
      (req.op inside {IORD_OP_IO_WR, IORD_OP_SET_BIT, IORD_OP_CLR_BIT}) |-> !ext_wr)
      else $error("short op reached extended region");
   a_resp_valid: assert property (@(posedge clk) disable iff (!rst_q)
      (req.op != IORD_OP_NONE) |=> rsp.valid)
      else $error("response valid missing");
   a_io_range: assert property (@(posedge clk) disable iff (!rst_q)
      (req.op == IORD_OP_IO_WR && req.addr[7:6] != 2'b00) |=> rsp.reject)
      else $error("short op beyond 64 accepted");
   a_data_alias: assert property (@(posedge clk) disable iff (!rst_q)
      (req.op == IORD_OP_DATA_ST && req.addr == 8'h3e) |=> regs_q[6'h1e] == $past(req.wdata))
      else $error("data view alias wrong");
   a_ext_route: assert property (@(posedge clk) disable iff (!rst_q)
      (req.op == IORD_OP_DATA_ST && req.addr >= 8'h60) |-> ext_wr ##1 $stable(regs_q))
      else $error("extended store misrouted");
   a_resv_read: assert property (@(posedge clk) disable iff (!rst_q)
      (req.op == IORD_OP_IO_RD && req.addr == 8'h0c) |=> rsp.rdata == 8'h00)
      else $error("reserved read nonzero");
endmodule
`default_nettype wire

// ---- verification/iord_ext_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module iord_ext_model (
   input wire logic clk,
   input wire logic [7:0] ext_addr,
   input wire logic ext_wr,
   input wire logic [7:0] ext_wdata,
   output logic [7:0] ext_rdata
);
   logic [7:0] mem [256];
   logic [7:0] idle_q = 8'h00;
   // stores land only in the extended region
   always @(posedge clk) begin
      idle_q <= ~idle_q;
      if (ext_wr && ext_addr >= 8'h60) begin
         mem[ext_addr] <= ext_wdata;
      end
   end
   // outside the region the bus shows a toggling pattern
   assign ext_rdata = (ext_addr >= 8'h60) ? mem[ext_addr] : idle_q;
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
   import iord_pkg::*;
   logic clk, resetn, ext_wr;
   iord_req_s req;
   iord_rsp_s rsp;
   logic [7:0] ext_addr, ext_wdata, ext_rdata;
   logic [31:0] pin_levels;
   logic [511:0] flag_set;
   logic [63:0][7:0] reg_out;
   int err_count, samples_checked;
   iord_decoder dut (.clk(clk), .resetn(resetn), .req(req), .rsp(rsp), .ext_addr(ext_addr),
      .ext_wr(ext_wr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
      .pin_levels(pin_levels), .flag_set(flag_set), .reg_out(reg_out));
   iord_ext_model ext (.clk(clk), .ext_addr(ext_addr), .ext_wr(ext_wr),
      .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic give_verdict();
      if (err_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // request held until its taking edge, answer read just after it
   task automatic acc(input iord_op_e op, input logic [7:0] a, input logic [2:0] b,
      input logic [7:0] wd);
      req = '{op: op, addr: a, bit_sel: b, wdata: wd};
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input iord_op_e op, input logic [7:0] a, input logic [7:0] exp);
      acc(op, a, 3'h0, 8'h00);
      chk(rsp.rdata, exp);
   endtask
   initial begin
      #(40 * 400);
      err_count++;
      give_verdict();
   end
   initial begin
      err_count = 0;
      samples_checked = 0;
      resetn = 1'b0;
      req = '0;
      pin_levels = 32'h44332211;
      flag_set = '0;
      repeat (8) @(posedge clk);
      #1;
      resetn = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      rd(IORD_OP_IO_RD, 8'h1e, 8'h00);
      acc(IORD_OP_IO_WR, 8'h1e, 3'h0, 8'h5a);
      chk(reg_out[6'h1e], 8'h5a);
      rd(IORD_OP_IO_RD, 8'h1e, 8'h5a);
      rd(IORD_OP_DATA_LD, 8'h3e, 8'h5a);
      acc(IORD_OP_DATA_ST, 8'h22, 3'h0, 8'ha5);
      rd(IORD_OP_IO_RD, 8'h02, 8'ha5);
      acc(IORD_OP_SET_BIT, 8'h02, 3'h3, 8'h00);
      rd(IORD_OP_IO_RD, 8'h02, 8'had);
      acc(IORD_OP_CLR_BIT, 8'h02, 3'h0, 8'h00);
      rd(IORD_OP_IO_RD, 8'h02, 8'hac);
      acc(IORD_OP_TEST_BIT, 8'h02, 3'h3, 8'h00);
      chk({7'h00, rsp.bit_val}, 8'h01);
      acc(IORD_OP_TEST_BIT, 8'h02, 3'h0, 8'h00);
      chk({7'h00, rsp.bit_val}, 8'h00);
      acc(IORD_OP_SET_BIT, 8'h20, 3'h0, 8'h00);
      chk({7'h00, rsp.reject}, 8'h01);
      rd(IORD_OP_IO_RD, 8'h20, 8'h00);
      acc(IORD_OP_IO_RD, 8'h40, 3'h0, 8'h00);
      chk({7'h00, rsp.reject}, 8'h01);
      chk({7'h00, rsp.valid}, 8'h01);
      acc(IORD_OP_DATA_LD, 8'h10, 3'h0, 8'h00);
      chk({7'h00, rsp.reject}, 8'h01);
      acc(IORD_OP_DATA_ST, 8'h80, 3'h0, 8'h3c);
      acc(IORD_OP_IO_WR, 8'h80, 3'h0, 8'hc3);
      chk({7'h00, rsp.reject}, 8'h01);
      rd(IORD_OP_DATA_LD, 8'h80, 8'h3c);
      chk({7'h00, rsp.ext_sel}, 8'h01);
      rd(IORD_OP_IO_RD, 8'h0c, 8'h00);
      acc(IORD_OP_IO_WR, 8'h1d, 3'h0, 8'h05);
      rd(IORD_OP_IO_RD, 8'h1d, 8'h05);
      acc(IORD_OP_IO_WR, 8'h15, 3'h0, 8'h07);
      rd(IORD_OP_IO_RD, 8'h15, 8'h00);
      flag_set[8'h15*8] = 1'b1;
      acc(IORD_OP_NONE, 8'h00, 3'h0, 8'h00);
      flag_set = '0;
      chk(reg_out[6'h15], 8'h01);
      flag_set[8'h1c*8] = 1'b1;
      acc(IORD_OP_IO_WR, 8'h1c, 3'h0, 8'h01);
      flag_set = '0;
      chk(reg_out[6'h1c], 8'h01);
      acc(IORD_OP_SET_BIT, 8'h15, 3'h0, 8'h00);
      rd(IORD_OP_IO_RD, 8'h15, 8'h00);
      rd(IORD_OP_IO_RD, 8'h00, 8'h11);
      rd(IORD_OP_DATA_LD, 8'h29, 8'h44);
      acc(IORD_OP_IO_WR, 8'h03, 3'h0, 8'h00);
      rd(IORD_OP_IO_RD, 8'h03, 8'h22);
      acc(IORD_OP_NONE, 8'h00, 3'h0, 8'h00);
      chk({7'h00, rsp.valid}, 8'h00);
      give_verdict();
   end
endmodule
`default_nettype wire
